// ### rtl/ieb_bank.sv
// upper interrupt enable bank with wishbone slave and sticky summary interrupt
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
module ieb_bank #(
	parameter bit HAS_CAN = 1'b1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [4:0]       wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	input  wire ieb_pkg::ieb_vec_t pend_i,
	input  wire ieb_pkg::ieb_vec_t prio_zero_i,
	output ieb_pkg::ieb_vec_t     req_o,
	output logic                  irq_o
);
	import ieb_pkg::*;

	localparam logic [15:0] MASKS [IEB_NUM_GROUPS] = '{IEB_MASK_EN4, IEB_MASK_EN5, IEB_MASK_EN6, IEB_MASK_EN7};

	logic [15:0]        en_reg [IEB_NUM_GROUPS];
	logic [IEB_ST_W-1:0] stat_reg;
	logic [IEB_ST_W-1:0] imask_reg;
	logic               req_any_d_reg;
	ieb_vec_t           req_next;
	logic               acc;
	logic               wr_lo;
	logic               wr_hi;
	logic               mapped;
	logic               req_any;

	//////////////////////////////////////////////////////////////////////////////
	// bus decode; ack lasts one running cycle so a held request is not taken twice
	assign acc    = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
	assign wr_lo  = acc && wb_we_i && wb_sel_i[0];
	assign wr_hi  = acc && wb_we_i && wb_sel_i[1];
	assign mapped = (wb_adr_i <= IEB_OFF_MASK) && (wb_adr_i[1:0] == 2'h0);

	// one enable register per group, masked so reserved bits never store
	genvar g;
	generate
		for (g = 0; g < IEB_NUM_GROUPS; g++)
		begin : g_en
			localparam logic [4:0] OFF = 5'(4 * g);
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					en_reg[g] <= IEB_RST_EN;
				else if (wb_adr_i == OFF)
				begin
					if (wr_lo)
						en_reg[g][7:0] <= wb_dat_i[7:0] & MASKS[g][7:0];
					if (wr_hi)
						en_reg[g][15:8] <= wb_dat_i[15:8] & MASKS[g][15:8];
				end
			end
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////////
	// request gating; pending flags live in the sources and are untouched here
	always_comb
	begin
		req_next    = pend_i & {en_reg[3], en_reg[2], en_reg[1], en_reg[0]};
		req_next    = req_next & ~prio_zero_i;
		req_next.g4 = req_next.g4 & IEB_MASK_EN4;
		req_next.g5 = req_next.g5 & IEB_MASK_EN5;
		req_next.g6 = req_next.g6 & IEB_MASK_EN6;
		req_next.g7 = req_next.g7 & IEB_MASK_EN7;
		if (!HAS_CAN)
			req_next.g4[IEB_BIT_CANTX] = 1'b0;
	end

	// registered request outputs, one cycle behind pending and enable
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			req_o <= '0;
		else if (ce_i)
			req_o <= req_next;
	end

	//////////////////////////////////////////////////////////////////////////////
	// sticky status: set on rising summary request or unmapped access; set wins
	assign req_any = |req_next;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			req_any_d_reg <= 1'b0;
		else if (ce_i)
			req_any_d_reg <= req_any;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			stat_reg <= IEB_RST_ST;
		else if (ce_i)
		begin
			for (int i = 0; i < IEB_ST_W; i++)
			begin
				if ((i == IEB_ST_REQ && req_any && !req_any_d_reg) || (i == IEB_ST_BADADR && acc && !mapped))
					stat_reg[i] <= 1'b1;
				else if (wr_lo && wb_adr_i == IEB_OFF_STAT && wb_dat_i[i])
					stat_reg[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			imask_reg <= IEB_RST_ST;
		else if (wr_lo && wb_adr_i == IEB_OFF_MASK)
			imask_reg <= wb_dat_i[IEB_ST_W-1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else if (ce_i)
			irq_o <= |(stat_reg & imask_reg);
	end

	//////////////////////////////////////////////////////////////////////////////
	// ack and read data; upper bits and unimplemented bits return zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else if (ce_i)
		begin
			wb_ack_o <= acc;
			if (acc && !wb_we_i)
			begin
				case (wb_adr_i)
					IEB_OFF_EN4:  wb_dat_o <= {16'h0000, en_reg[0] & IEB_MASK_EN4};
					IEB_OFF_EN5:  wb_dat_o <= {16'h0000, en_reg[1] & IEB_MASK_EN5};
					IEB_OFF_EN6:  wb_dat_o <= {16'h0000, en_reg[2] & IEB_MASK_EN6};
					IEB_OFF_EN7:  wb_dat_o <= {16'h0000, en_reg[3] & IEB_MASK_EN7};
					IEB_OFF_STAT: wb_dat_o <= {30'h0, stat_reg};
					IEB_OFF_MASK: wb_dat_o <= {30'h0, imask_reg};
					default:      wb_dat_o <= IEB_BAD_DATA;
				endcase
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_wr_en4;
		wr_lo && wb_adr_i == IEB_OFF_EN4;
	endsequence

	sequence s_wr_en4_hi;
		wr_hi && wb_adr_i == IEB_OFF_EN4;
	endsequence

	sequence s_wr_en5;
		wr_lo && wr_hi && wb_adr_i == IEB_OFF_EN5;
	endsequence

	sequence s_wr_en6;
		wr_lo && wr_hi && wb_adr_i == IEB_OFF_EN6;
	endsequence

	sequence s_wr_en7;
		wr_lo && wb_adr_i == IEB_OFF_EN7;
	endsequence

	// a take, then one running cycle in which ack is shown and must be dropped
	sequence s_take_run;
		acc ##1 ce_i;
	endsequence

	property p_gate;
		@(posedge clk_i) disable iff (rst_i)
		ce_i |=> (req_o & ~$past(pend_i & {en_reg[3], en_reg[2], en_reg[1], en_reg[0]})) == 64'h0;
	endproperty
	a_gate: assert property (p_gate) else $error("request without pending flag and enable");

	property p_resv4;
		@(posedge clk_i) disable iff (rst_i)
		(en_reg[0] & ~IEB_MASK_EN4) == 16'h0000 && (en_reg[1] & ~IEB_MASK_EN5) == 16'h0000;
	endproperty
	a_resv4: assert property (p_resv4) else $error("reserved bit stored");

	property p_reset;
		@(posedge clk_i) rst_i |=> en_reg[0] == 16'h0000 && en_reg[2] == 16'h0000 && !irq_o;
	endproperty
	a_reset: assert property (p_reset) else $error("enable not cleared by reset");

	property p_can;
		@(posedge clk_i) disable iff (rst_i)
		!HAS_CAN |-> !req_o.g4[IEB_BIT_CANTX];
	endproperty
	a_can: assert property (p_can) else $error("can request without controller");

	property p_g4wr;
		@(posedge clk_i) disable iff (rst_i)
		s_wr_en4 |=> en_reg[0][7:0] == ($past(wb_dat_i[7:0]) & 8'h46);
	endproperty
	a_g4wr: assert property (p_g4wr) else $error("group4 low byte write wrong");

	property p_g7hi;
		@(posedge clk_i) disable iff (rst_i)
		req_o.g7[15:6] == 10'h000 && req_o.g5[12:5] == 8'h00;
	endproperty
	a_g7hi: assert property (p_g7hi) else $error("request on unimplemented bit");

	property p_prio;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && prio_zero_i.g6[0] |=> !req_o.g6[0];
	endproperty
	a_prio: assert property (p_prio) else $error("priority zero source requested");

	property p_stable;
		@(posedge clk_i) disable iff (rst_i)
		!(wr_lo || wr_hi) |=> $stable(en_reg[3]) && $stable(en_reg[1]);
	endproperty
	a_stable: assert property (p_stable) else $error("enable changed without write");

	property p_ack;
		@(posedge clk_i) disable iff (rst_i)
		acc |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack missing after take");

	// a frozen cycle may stretch ack, so the drop is only owed after a running one
	property p_ack_drop;
		@(posedge clk_i) disable iff (rst_i)
		s_take_run |=> !wb_ack_o;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack not single cycle");

	//////////////////////////////////////////////////////////////////////////////
	// field placement: each write lands only on the implemented enable positions
	property p_g4hi;
		@(posedge clk_i) disable iff (rst_i)
		s_wr_en4_hi |=> en_reg[0][IEB_BIT_ENC2] == $past(wb_dat_i[IEB_BIT_ENC2])
			&& en_reg[0][IEB_BIT_PWMSEC] == $past(wb_dat_i[IEB_BIT_PWMSEC]) && en_reg[0][15:12] == 4'h0;
	endproperty
	a_g4hi: assert property (p_g4hi) else $error("group4 high byte field wrong");

	property p_g4lo;
		@(posedge clk_i) disable iff (rst_i)
		s_wr_en4 |=> en_reg[0][IEB_BIT_CANTX] == $past(wb_dat_i[IEB_BIT_CANTX])
			&& en_reg[0][IEB_BIT_UART2E] == $past(wb_dat_i[IEB_BIT_UART2E])
			&& en_reg[0][IEB_BIT_UART1E] == $past(wb_dat_i[IEB_BIT_UART1E]);
	endproperty
	a_g4lo: assert property (p_g4lo) else $error("group4 low byte field wrong");

	property p_g5wr;
		@(posedge clk_i) disable iff (rst_i)
		s_wr_en5 |=> en_reg[1] == ($past(wb_dat_i[15:0]) & IEB_MASK_EN5);
	endproperty
	a_g5wr: assert property (p_g5wr) else $error("group5 write wrong");

	property p_g6wr;
		@(posedge clk_i) disable iff (rst_i)
		s_wr_en6 |=> en_reg[2] == ($past(wb_dat_i[15:0]) & IEB_MASK_EN6);
	endproperty
	a_g6wr: assert property (p_g6wr) else $error("group6 write wrong");

	property p_g7wr;
		@(posedge clk_i) disable iff (rst_i)
		s_wr_en7 |=> en_reg[3][7:0] == ($past(wb_dat_i[7:0]) & IEB_MASK_EN7[7:0]);
	endproperty
	a_g7wr: assert property (p_g7wr) else $error("group7 write wrong");

	property p_resv67;
		@(posedge clk_i) disable iff (rst_i)
		(en_reg[2] & ~IEB_MASK_EN6) == 16'h0000 && (en_reg[3] & ~IEB_MASK_EN7) == 16'h0000;
	endproperty
	a_resv67: assert property (p_resv67) else $error("reserved bit stored in group6 or 7");

	property p_rdhi;
		@(posedge clk_i) disable iff (rst_i)
		acc && !wb_we_i |=> wb_dat_o[31:16] == 16'h0000;
	endproperty
	a_rdhi: assert property (p_rdhi) else $error("upper read half not zero");

	//////////////////////////////////////////////////////////////////////////////
	// reset, blocking, status and the summary interrupt
	property p_rst_all;
		@(posedge clk_i)
		rst_i |=> en_reg[1] == 16'h0000 && en_reg[3] == 16'h0000 && req_o == 64'h0
			&& stat_reg == IEB_RST_ST && !wb_ack_o;
	endproperty
	a_rst_all: assert property (p_rst_all) else $error("state not cleared by reset");

	property p_blk7;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && en_reg[3] == 16'h0000 |=> req_o.g7 == 16'h0000;
	endproperty
	a_blk7: assert property (p_blk7) else $error("group7 request passed while disabled");

	property p_blk5;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && en_reg[1] == 16'h0000 |=> req_o.g5 == 16'h0000;
	endproperty
	a_blk5: assert property (p_blk5) else $error("group5 request passed while disabled");

	property p_badadr;
		@(posedge clk_i) disable iff (rst_i)
		acc && !mapped |=> stat_reg[IEB_ST_BADADR];
	endproperty
	a_badadr: assert property (p_badadr) else $error("unmapped access not flagged");

	property p_irq;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && (stat_reg & imask_reg) != '0 |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt low with unmasked status");

	property p_noirq;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && (stat_reg & imask_reg) == '0 |=> !irq_o;
	endproperty
	a_noirq: assert property (p_noirq) else $error("interrupt high with no unmasked status");

	property p_freeze;
		@(posedge clk_i) disable iff (rst_i)
		!ce_i |=> $stable(req_o) && $stable(irq_o) && $stable(stat_reg) && $stable(imask_reg)
			&& $stable(wb_ack_o) && $stable(wb_dat_o) && $stable(en_reg[0]) && $stable(en_reg[2]);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
endmodule

// ### rtl/ieb_pkg.sv
// package for the upper interrupt enable bank: offsets, masks, resets, carriers
package ieb_pkg;
	localparam int          IEB_NUM_GROUPS  = 4;
	localparam int          IEB_AW          = 5;
	// byte offsets of the bank registers on the bus
	localparam logic [4:0]  IEB_OFF_EN4     = 5'h00;
	localparam logic [4:0]  IEB_OFF_EN5     = 5'h04;
	localparam logic [4:0]  IEB_OFF_EN6     = 5'h08;
	localparam logic [4:0]  IEB_OFF_EN7     = 5'h0C;
	localparam logic [4:0]  IEB_OFF_STAT    = 5'h10;
	localparam logic [4:0]  IEB_OFF_MASK    = 5'h14;
	// implemented bit masks per group
	localparam logic [15:0] IEB_MASK_EN4    = 16'h0A46;
	localparam logic [15:0] IEB_MASK_EN5    = 16'hE01E;
	localparam logic [15:0] IEB_MASK_EN6    = 16'hC3FF;
	localparam logic [15:0] IEB_MASK_EN7    = 16'h003F;
	localparam logic [15:0] IEB_RST_EN      = 16'h0000;
	// field positions in group 4
	localparam int          IEB_BIT_ENC2    = 11;
	localparam int          IEB_BIT_PWMSEC  = 9;
	localparam int          IEB_BIT_CANTX   = 6;
	localparam int          IEB_BIT_UART2E  = 2;
	localparam int          IEB_BIT_UART1E  = 1;
	// status bits: 0 = request rose, 1 = unmapped access
	localparam int          IEB_ST_W        = 2;
	localparam int          IEB_ST_REQ      = 0;
	localparam int          IEB_ST_BADADR   = 1;
	localparam logic [1:0]  IEB_RST_ST      = 2'h0;
	localparam logic [31:0] IEB_BAD_DATA    = 32'h0000_0000;

	typedef struct packed {
		logic [15:0] g7;
		logic [15:0] g6;
		logic [15:0] g5;
		logic [15:0] g4;
	} ieb_vec_t;
endpackage

// ### verification/ieb_src_model.sv
// peripheral source model: sticky pending flags and priority-zero flags
`timescale 1ns/10ps
module ieb_src_model
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire ieb_pkg::ieb_vec_t set_i,
	input  wire ieb_pkg::ieb_vec_t clr_i,
	input  wire ieb_pkg::ieb_vec_t pz_i,
	output ieb_pkg::ieb_vec_t      pend_o,
	output ieb_pkg::ieb_vec_t      prio_zero_o
);
	import ieb_pkg::*;
	// a flag stays up until its source clears it; the enable never touches it
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pend_o      <= '0;
			prio_zero_o <= '0;
		end
		else
		begin
			pend_o      <= ieb_vec_t'((pend_o | set_i) & ~clr_i);
			prio_zero_o <= pz_i;
		end
	end
endmodule

// ### verification/ieb_bank_test.sv
// self-checking bench for the upper enable bank
`timescale 1ns/10ps
module ieb_bank_test;
	import ieb_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        ce    = 1'b1;
	logic        cyc   = 1'b0;
	logic        stb   = 1'b0;
	logic        we    = 1'b0;
	logic [4:0]  adr   = 5'h00;
	logic [3:0]  sel   = 4'h0;
	logic [31:0] dat   = 32'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic        ack;
	logic        irq;
	ieb_vec_t    set_v = '0;
	ieb_vec_t    clr_v = '0;
	ieb_vec_t    pz_v  = '0;
	ieb_vec_t    pend;
	ieb_vec_t    pz;
	ieb_vec_t    req;
	ieb_vec_t    hold_v;
	logic [15:0] en [4];
	int          mismatches = 0;
	int          tests_run  = 0;
	localparam logic [15:0] MSK [4] = '{IEB_MASK_EN4, IEB_MASK_EN5, IEB_MASK_EN6, IEB_MASK_EN7};

	// 50 MHz clock
	always #10 clk_i = ~clk_i;

	// no CAN controller, so the transmit request must stay blocked
	ieb_bank #(.HAS_CAN(1'b0)) u_ieb_bank (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .pend_i(pend), .prio_zero_i(pz), .req_o(req), .irq_o(irq));
	ieb_src_model u_ieb_src_model (.clk_i(clk_i), .rst_i(rst_i), .set_i(set_v), .clr_i(clr_v),
		.pz_i(pz_v), .pend_o(pend), .prio_zero_o(pz));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// classic cycle: hold everything until ack is sampled, then one idle cycle
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		q = rdat;
		if (n >= 50)
			chk(1'b0, 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask

	// pulse the source model, then let flags and requests settle
	task automatic src(input ieb_vec_t s, input ieb_vec_t c);
		set_v <= s;
		clr_v <= c;
		@(posedge clk_i);
		set_v <= '0;
		clr_v <= '0;
		repeat (3) @(posedge clk_i);
	endtask

	function automatic ieb_vec_t exp_f(ieb_vec_t p, ieb_vec_t z);
		ieb_vec_t e;
		e = ieb_vec_t'(p & ~z & {en[3] & MSK[3], en[2] & MSK[2], en[1] & MSK[1], en[0] & MSK[0]});
		e.g4[IEB_BIT_CANTX] = 1'b0;
		return e;
	endfunction

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// watchdog: the whole run needs well under 5000 cycles
	initial
	begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		wrap_up();
	end

	// main sequence
	initial
	begin
		void'($urandom(32'h48a3));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int i = 0; i < 4; i++)
		begin
			wb(1'b0, 5'(i * 4), 32'h0, 4'hF);
			chk(q, 64'h0);
			wb(1'b1, 5'(i * 4), 32'hFFFF_FFFF, 4'h1);
			wb(1'b0, 5'(i * 4), 32'h0, 4'hF);
			chk(q, {48'h0, MSK[i] & 16'h00FF});
			wb(1'b1, 5'(i * 4), 32'hFFFF_FFFF, 4'hF);
			wb(1'b0, 5'(i * 4), 32'h0, 4'hF);
			chk(q, {48'h0, MSK[i]});
		end
		// upper byte lanes and an unaligned address never reach an enable
		wb(1'b1, IEB_OFF_EN5, 32'h0, 4'hC);
		wb(1'b1, 5'h05, 32'h0, 4'h3);
		wb(1'b0, IEB_OFF_EN5, 32'h0, 4'hF);
		chk(q, {48'h0, MSK[1]});
		chk(req, 64'h0);
		chk(irq, 1'b0);
		$display("register map test done");
		// random enables, flags and disabled priorities
		for (int t = 0; t < 20; t++)
		begin
			for (int i = 0; i < 4; i++)
			begin
				en[i] = 16'($urandom);
				wb(1'b1, 5'(i * 4), {16'hFFFF, en[i]}, 4'h3);
			end
			pz_v <= ieb_vec_t'({$urandom, $urandom});
			src(ieb_vec_t'({$urandom, $urandom}), ieb_vec_t'({$urandom, $urandom}));
			chk(req, exp_f(pend, pz));
		end
		$display("request gating test done");
		// clock enable low: requests hold while the sources drop every flag
		hold_v = req;
		ce     <= 1'b0;
		src('0, '1);
		chk(req, hold_v);
		ce     <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(req, 64'h0);
		$display("clock enable test done");
		// sticky status, mask and the level interrupt
		pz_v <= '0;
		src('0, '1);
		wb(1'b1, IEB_OFF_STAT, 32'h3, 4'h1);
		wb(1'b0, 5'h18, 32'h0, 4'hF);
		chk(q, 64'h0);
		wb(1'b0, IEB_OFF_STAT, 32'h0, 4'hF);
		chk({q, irq}, 33'h4);
		wb(1'b1, IEB_OFF_MASK, 32'h2, 4'h1);
		repeat (2) @(posedge clk_i);
		chk(irq, 1'b1);
		wb(1'b1, IEB_OFF_STAT, 32'h2, 4'h1);
		wb(1'b1, IEB_OFF_EN7, 32'h1, 4'h1);
		en[3] = 16'h1;
		wb(1'b1, IEB_OFF_MASK, 32'h1, 4'h1);
		chk(irq, 1'b0);
		src(ieb_vec_t'(64'h0001_0000_0000_0000), '0);
		chk({req.g7, irq}, 17'h3);
		$display("interrupt test done");
		wrap_up();
	end
endmodule
